// ### common/bus_glue_pkg.sv
// Shared constants and carrier types for the host bus glue block
package bus_glue_pkg;
   localparam int HOST_ADDR_W = 24;
   localparam int HOST_DATA_W = 16;
   localparam int SYS_ADDR_W = 32;
   localparam int DMA_CHANNELS = 3;
   localparam int DMA_COUNT_W = 24;
   localparam int IRQ_SOURCES = 21;
   localparam logic [1:0] CH_AI = 2'h0;
   localparam logic [1:0] CH_AO = 2'h1;
   localparam logic [1:0] CH_GPCT = 2'h2;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TIMER_RES_PS = 50000;
   localparam int TICK_CYCLES = (TIMER_RES_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TICK_W = 4;

   // Host programmed access towards the internal bus
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] size;
      logic [HOST_ADDR_W-1:0] addr;
      logic [HOST_DATA_W-1:0] data;
   } host_req_t;

   // Setup of one DMA channel
   typedef struct packed {
      logic start;
      logic to_memory;
      logic [SYS_ADDR_W-1:0] mem_addr;
      logic [DMA_COUNT_W-1:0] count;
   } dma_cfg_t;

   // One bus-master beat to system memory
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] channel;
      logic [SYS_ADDR_W-1:0] addr;
      logic [HOST_DATA_W-1:0] data;
   } mem_req_t;
endpackage : bus_glue_pkg

// ### testbench/bus_glue_monitor.sv
// Checker of the host bus glue ports
`timescale 1ns/1ps
`default_nettype none
module bus_glue_monitor (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire bus_glue_pkg::host_req_t host_req, // Host access
   input wire logic host_ack, // Taken
   input wire logic host_refused, // Refused
   input wire bus_glue_pkg::host_req_t local_req, // Passed on
   input wire bus_glue_pkg::mem_req_t mem_req, // Master beat
   input wire logic mem_ready, // Beat taken
   input wire logic first_interrupt_output, // Interrupt in
   input wire logic inta_n_o, // INTA level
   input wire logic inta_n_oe, // INTA enable
   input wire logic timing_tick // Tick
);
   import bus_glue_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_WIDE: assert property (host_req.valid && host_req.size[1]
      |-> host_refused && !host_ack ##1 !local_req.valid) else $error("wide taken");
   AST_NARROW: assert property (host_req.valid && !host_req.size[1]
      |-> host_ack ##1 local_req == $past(host_req)) else $error("narrow lost");
   AST_INTA: assert property (first_interrupt_output |=> inta_n_oe)
      else $error("inta not raised");
   AST_FREE: assert property (!first_interrupt_output |=> !inta_n_oe)
      else $error("inta not freed");
   AST_LOW: assert property (inta_n_oe |-> !inta_n_o) else $error("inta level");
   AST_HOLD: assert property (mem_req.valid && !mem_ready |=> $stable(mem_req))
      else $error("beat changed");
   AST_GAP: assert property (mem_req.valid && mem_ready |=> !mem_req.valid)
      else $error("no gap");
   AST_TICK: assert property (timing_tick |-> ##13 timing_tick)
      else $error("tick period");
   AST_TICK_GAP: assert property (timing_tick |=> !timing_tick [*8])
      else $error("tick too early");
   cover property (host_refused);
   cover property (mem_req.valid && mem_ready);
   cover property (inta_n_oe);
endmodule : bus_glue_monitor
bind pci_board_bus_glue bus_glue_monitor mon (
   .clk(clk),
   .rst(rst),
   .host_req(host_req),
   .host_ack(host_ack),
   .host_refused(host_refused),
   .local_req(local_req),
   .mem_req(mem_req),
   .mem_ready(mem_ready),
   .first_interrupt_output(first_interrupt_output),
   .inta_n_o(inta_n_o),
   .inta_n_oe(inta_n_oe),
   .timing_tick(timing_tick)
);
`default_nettype wire

// ### testbench/mem_model.sv
// System memory answering master beats
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire bus_glue_pkg::mem_req_t mem_req, // Beat
   input wire logic [3:0] slow, // Wait cycles
   output logic mem_ready, // Taken
   output logic [15:0] mem_rdata, // Read data
   output logic [7:0] beats // Beats taken
);
   import bus_glue_pkg::*;
   logic [3:0] wait_reg;
   // Outside a taken beat the bus shows the inverse, never a stale copy
   assign mem_rdata = mem_req.addr[15:0] ^ 16'h5A5A ^ {16{!mem_ready}};
   always_ff @(posedge clk) begin
      wait_reg <= (rst || !mem_req.valid || mem_ready) ? 4'h0 : wait_reg + 4'h1;
      mem_ready <= !rst && mem_req.valid && !mem_ready && wait_reg >= slow;
      beats <= rst ? 8'h00 : beats + {7'h00, mem_req.valid && mem_ready};
   end
endmodule : mem_model
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the host bus glue
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bus_glue_pkg::*;
   logic clk, rst, host_ack, host_refused, cfg_we, mem_ready, first_interrupt_output;
   logic inta_n_o, inta_n_oe, timing_tick;
   host_req_t host_req, local_req;
   logic [31:0] cfg_base, base_addr;
   logic [7:0] cfg_irq_line, irq_line, beats;
   dma_cfg_t dma_cfg [DMA_CHANNELS];
   logic [2:0] dma_dreq, board_wstrobe, dma_busy, dma_done;
   logic [15:0] board_rdata [DMA_CHANNELS];
   logic [15:0] mem_rdata, board_wdata;
   mem_req_t mem_req;
   mem_req_t nd_req;
   logic [2:0] nd_busy;
   logic [3:0] slow;
   int err_count, n_tests;
   pci_board_bus_glue dut (
      .clk(clk),
      .rst(rst),
      .host_req(host_req),
      .host_ack(host_ack),
      .host_refused(host_refused),
      .local_req(local_req),
      .cfg_we(cfg_we),
      .cfg_base(cfg_base),
      .cfg_irq_line(cfg_irq_line),
      .base_addr(base_addr),
      .irq_line(irq_line),
      .dma_cfg(dma_cfg),
      .dma_dreq(dma_dreq),
      .board_rdata(board_rdata),
      .mem_req(mem_req),
      .mem_ready(mem_ready),
      .mem_rdata(mem_rdata),
      .board_wstrobe(board_wstrobe),
      .board_wdata(board_wdata),
      .dma_busy(dma_busy),
      .dma_done(dma_done),
      .first_interrupt_output(first_interrupt_output),
      .inta_n_o(inta_n_o),
      .inta_n_oe(inta_n_oe),
      .timing_tick(timing_tick)
   );
   // Early revision build: the same starts must never move a beat
   pci_board_bus_glue #(.DMA_PRESENT(1'b0)) no_dma (
      .clk(clk),
      .rst(rst),
      .host_req(host_req),
      .host_ack(),
      .host_refused(),
      .local_req(),
      .cfg_we(cfg_we),
      .cfg_base(cfg_base),
      .cfg_irq_line(cfg_irq_line),
      .base_addr(),
      .irq_line(),
      .dma_cfg(dma_cfg),
      .dma_dreq(dma_dreq),
      .board_rdata(board_rdata),
      .mem_req(nd_req),
      .mem_ready(mem_ready),
      .mem_rdata(mem_rdata),
      .board_wstrobe(),
      .board_wdata(),
      .dma_busy(nd_busy),
      .dma_done(),
      .first_interrupt_output(first_interrupt_output),
      .inta_n_o(),
      .inta_n_oe(),
      .timing_tick()
   );
   mem_model mem (
      .clk(clk),
      .rst(rst),
      .mem_req(mem_req),
      .slow(slow),
      .mem_ready(mem_ready),
      .mem_rdata(mem_rdata),
      .beats(beats)
   );
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic t_host();
      for (int s = 0; s < 4; s++) begin
         host_req = '{1'b1, s[0], s[1:0], 24'h00ABC0, 16'hC3A5};
         #1;
         chk({host_ack, host_refused}, {s < 2, s > 1});
         step();
         chk(local_req, s < 2 ? {1'b1, s[0], s[1:0], 40'hABC0C3A5} : 0);
      end
      host_req.valid = 1'b0;
      $display("host done");
   endtask : t_host
   task automatic t_cfg();
      cfg_base = 32'hFEDC1200;
      cfg_irq_line = 8'h0B;
      cfg_we = 1'b1;
      step();
      cfg_we = 1'b0;
      cfg_base = 32'h0;
      step();
      chk({base_addr, irq_line}, {32'hFEDC1200, 8'h0B});
      $display("config done");
   endtask : t_cfg
   task automatic t_irq();
      first_interrupt_output = 1'b1;
      step();
      chk({inta_n_oe, inta_n_o}, 2'h2);
      first_interrupt_output = 1'b0;
      step();
      chk(inta_n_oe, 1'h0);
      $display("irq done");
   endtask : t_irq
   task automatic t_dma();
      logic [15:0] wd;
      logic [2:0] seen;
      logic [2:0] nd_seen;
      seen = 3'h0;
      nd_seen = 3'h0;
      for (int c = 0; c < 3; c++) dma_cfg[c] = '{1'b1, c != 1, 32'h1000 * (c + 1), 24'h2};
      step();
      chk(dma_busy, 3'h7);
      for (int c = 0; c < 3; c++) dma_cfg[c].start = 1'b0;
      for (int i = 0; i < 300 && seen != 3'h7; i++) begin
         step();
         seen |= dma_done;
         nd_seen |= nd_busy | {3{nd_req.valid}};
         if (board_wstrobe[1]) wd = board_wdata;
      end
      chk({seen, beats, wd, dma_busy}, {3'h7, 8'h06, 16'h2002 ^ 16'h5A5A, 3'h0});
      chk(nd_seen, 3'h0);
      $display("dma done");
   endtask : t_dma
   task automatic t_tick();
      logic [7:0] n;
      n = 8'h00;
      repeat (130) begin
         step();
         n += timing_tick;
      end
      chk(n, 8'h0A);
      $display("tick done");
   endtask : t_tick
   initial begin
      {cfg_we, first_interrupt_output, host_req, cfg_base, cfg_irq_line} = '0;
      rst = 1'b1;
      slow = 4'h2;
      dma_dreq = 3'h7;
      board_rdata = '{16'h1111, 16'h2222, 16'h3333};
      for (int c = 0; c < 3; c++) dma_cfg[c] = '0;
      repeat (20) step();
      rst = 1'b0;
      t_host();
      t_cfg();
      t_irq();
      t_dma();
      t_tick();
      stop_test();
   end
   initial begin
      #20000;
      err_count++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire

// ### verilog/pci_board_bus_glue.sv
// Host bus glue: width filter, config hold, three DMA channels, merged interrupt
// Notes on behaviour
// RQ1 - Only byte and halfword host transfers accepted
// RQ2 - Three concurrent DMA channels: AI, AO, counters
// RQ3 - Over twenty interrupt sources routed toward INTA
// RQ4 - Interrupts only on INTA, never B/C/D
// RQ5 - Software routes all sources to first output
// RQ6 - Timing groups use a 50 ns tick; code ticks every 13 clocks, 52 ns
// RQ7 - Base address and level held, set by software
// RQ8 - Early low-speed variant has no DMA
// RQ9 - Bus master moves data without processor
// RQ10 - INTA active low level, released when clear
`timescale 1ns/1ps
`default_nettype none
module pci_board_bus_glue #(
   parameter bit DMA_PRESENT = 1'b1
) (
   input wire logic clk, // 250 MHz bus clock
   input wire logic rst, // Synchronous active high reset
   input wire bus_glue_pkg::host_req_t host_req, // Host programmed access
   output logic host_ack, // Access taken this cycle
   output logic host_refused, // Access refused: 32-bit width or unused size code
   output bus_glue_pkg::host_req_t local_req, // Access passed to internal bus
   input wire logic cfg_we, // Configuration write strobe
   input wire logic [bus_glue_pkg::SYS_ADDR_W-1:0] cfg_base, // Base memory address
   input wire logic [7:0] cfg_irq_line, // Interrupt level
   output logic [bus_glue_pkg::SYS_ADDR_W-1:0] base_addr, // Held base address
   output logic [7:0] irq_line, // Held interrupt level
   input wire bus_glue_pkg::dma_cfg_t dma_cfg [bus_glue_pkg::DMA_CHANNELS], // Per-channel setup
   input wire logic [bus_glue_pkg::DMA_CHANNELS-1:0] dma_dreq, // Board data ready per channel
   input wire logic [bus_glue_pkg::HOST_DATA_W-1:0] board_rdata [bus_glue_pkg::DMA_CHANNELS], // Board data
   output bus_glue_pkg::mem_req_t mem_req, // Master beat to memory
   input wire logic mem_ready, // Memory took the beat
   input wire logic [bus_glue_pkg::HOST_DATA_W-1:0] mem_rdata, // Data read from memory
   output logic [bus_glue_pkg::DMA_CHANNELS-1:0] board_wstrobe, // Memory data to board
   output logic [bus_glue_pkg::HOST_DATA_W-1:0] board_wdata, // Data for board
   output logic [bus_glue_pkg::DMA_CHANNELS-1:0] dma_busy, // Channel running
   output logic [bus_glue_pkg::DMA_CHANNELS-1:0] dma_done, // Channel finished pulse
   input wire logic first_interrupt_output, // Timing controller interrupt
   output logic inta_n_o, // INTA output level, low
   output logic inta_n_oe, // INTA enable, open drain
   output logic timing_tick // 52 ns tick (50 ns rounded up to 13 clocks) for timing groups
);
   import bus_glue_pkg::*;

   // One beat moves one halfword, so the address steps by its byte count
   localparam int BEAT_BYTES = HOST_DATA_W / 8;
   localparam logic [SYS_ADDR_W-1:0] ADDR_STEP = SYS_ADDR_W'(BEAT_BYTES);
   localparam logic [DMA_COUNT_W-1:0] LAST_BEAT = DMA_COUNT_W'(1);
   // Arbiter starts as if the last channel was served, so channel 0 goes first
   localparam logic [1:0] LAST_AT_RESET = 2'(DMA_CHANNELS - 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_BEAT = 2'b01
   } arb_state_t;

   // Width filter: 32-bit requests are refused, not split
   // The unused size code is refused as well, so only byte and halfword pass
   wire size_byte = host_req.size == SIZE_BYTE;
   wire size_half = host_req.size == SIZE_HALF;
   wire narrow_req = host_req.valid && (size_byte || size_half); // RQ1
   assign host_ack = narrow_req;
   assign host_refused = host_req.valid && !narrow_req; // RQ1

   // Refused or idle cycles leave zeros on the internal bus
   always_ff @(posedge clk) begin
      if (rst) local_req <= '0;
      else local_req <= narrow_req ? host_req : '0; // RQ1
   end

   // Held configuration, cleared at power on
   // Only software writes change these; the level is held for software only
   always_ff @(posedge clk) begin
      if (rst) begin
         base_addr <= '0;
         irq_line <= '0;
      end else if (cfg_we) begin
         base_addr <= cfg_base; // RQ7
         irq_line <= cfg_irq_line; // RQ7
      end
   end

   // 50 ns timebase; rounding up keeps intervals no shorter than stated
   logic [TICK_W-1:0] tick_cnt_reg;
   // TICK_W must hold TICK_LAST; the count wraps after TICK_CYCLES clocks
   wire tick_wrap = tick_cnt_reg == TICK_LAST;
   always_ff @(posedge clk) begin
      if (rst) tick_cnt_reg <= '0;
      else tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 1'b1; // RQ6
   end
   assign timing_tick = tick_wrap;

   // DMA channels; dir_reg set means board to memory, a write beat
   // A start while busy is ignored so a running transfer is never disturbed
   logic [SYS_ADDR_W-1:0] addr_reg [DMA_CHANNELS];
   logic [DMA_COUNT_W-1:0] left_reg [DMA_CHANNELS];
   logic [DMA_CHANNELS-1:0] dir_reg;
   logic [DMA_CHANNELS-1:0] want;
   logic [1:0] grant_reg;
   logic [1:0] last_reg;
   arb_state_t arb_reg;
   wire beat_done = (arb_reg == ARB_BEAT) && mem_ready;

   genvar g;
   generate
      for (g = 0; g < DMA_CHANNELS; g++) begin : gen_ch
         wire mine = beat_done && (grant_reg == 2'(g));
         wire last = left_reg[g] == LAST_BEAT;
         wire take = dma_cfg[g].start && !dma_busy[g] && DMA_PRESENT; // RQ8
         wire nonzero = dma_cfg[g].count != '0;
         // Without DMA the channels stay idle; software moves all data
         assign want[g] = dma_busy[g] && dma_dreq[g] && DMA_PRESENT; // RQ8
         always_ff @(posedge clk) begin
            if (rst) begin
               dma_busy[g] <= 1'b0;
               dma_done[g] <= 1'b0;
               addr_reg[g] <= '0;
               left_reg[g] <= '0;
               dir_reg[g] <= 1'b0;
            end else begin
               dma_done[g] <= mine && last;
               if (take) begin // RQ8
                  // A zero count is ignored: the channel stays idle
                  dma_busy[g] <= nonzero; // RQ2
                  addr_reg[g] <= dma_cfg[g].mem_addr;
                  left_reg[g] <= dma_cfg[g].count;
                  dir_reg[g] <= dma_cfg[g].to_memory;
               end else if (mine) begin
                  addr_reg[g] <= addr_reg[g] + ADDR_STEP; // RQ9
                  left_reg[g] <= left_reg[g] - 1'b1; // RQ9
                  dma_busy[g] <= !last; // RQ9
               end
            end
         end
      end
   endgenerate

   // Round robin from the channel after the last served, so none starves
   logic [1:0] pick;
   logic found;
   always_comb begin
      int k;
      logic [1:0] c;
      k = 0;
      c = '0;
      pick = '0;
      found = 1'b0;
      for (k = 1; k <= DMA_CHANNELS; k++) begin
         c = 2'((int'(last_reg) + k) % DMA_CHANNELS);
         if (!found && want[c]) begin
            pick = c; // RQ2
            found = 1'b1;
         end
      end
   end

   // Beat built from the picked channel; launched only from idle
   mem_req_t launch_beat;
   assign launch_beat = '{
      valid: 1'b1,
      write: dir_reg[pick],
      channel: pick,
      addr: addr_reg[pick],
      data: board_rdata[pick]
   };

   // The beat stands until memory takes it, then drops for one cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         arb_reg <= ARB_IDLE;
         grant_reg <= '0;
         last_reg <= LAST_AT_RESET;
         mem_req <= '0;
      end else begin
         unique case (arb_reg)
            ARB_IDLE: begin
               if (found) begin
                  arb_reg <= ARB_BEAT;
                  grant_reg <= pick;
                  mem_req <= launch_beat; // RQ9
               end
            end
            ARB_BEAT: begin
               if (mem_ready) begin
                  arb_reg <= ARB_IDLE;
                  last_reg <= grant_reg;
                  mem_req <= '0;
               end
            end
         endcase
      end
   end

   // Memory-to-board data lands on the granted channel
   // The strobe lasts one cycle; the data holds until the next read beat
   wire read_landed = beat_done && !mem_req.write;
   always_ff @(posedge clk) begin
      if (rst) begin
         board_wstrobe <= '0;
         board_wdata <= '0;
      end else begin
         board_wstrobe <= '0;
         if (read_landed) begin
            board_wstrobe[grant_reg] <= 1'b1; // RQ9
            board_wdata <= mem_rdata;
         end
      end
   end

   // Single level input carries every routed source; INTB..D do not exist here
   // Registered so the shared line never sees a combinational glitch
   logic irq_reg;
   always_ff @(posedge clk) begin
      if (rst) irq_reg <= 1'b0;
      else irq_reg <= first_interrupt_output; // RQ3 RQ5
   end
   // Open drain: the pin is only pulled low, released when nothing is pending
   assign inta_n_o = 1'b0; // RQ4
   assign inta_n_oe = irq_reg; // RQ10
endmodule : pci_board_bus_glue
`default_nettype wire
